// ### pio_pkg.sv
// Shared constants and types for the programmable general-purpose port block.
// Assumes one system clock with a synchronous active-low reset, and that
// pad cells outside resolve pin_out, pin_oe and pin_pullup into pin levels.
// How it works
// - Eighty-eight pins in eleven port groups, numbered zero to ten.
// - One direction bit per pin selects input or output.
// - Every data bit has an output latch and a separate pin-sampling read path.
// - Input pins read the sampled level; writes only load the latch.
// - Output pins read the latch, and the latch drives the pin.
// - One pull-up bit per four pins, applied only to pins in input mode.
// - Port eight bit five is input only, unpulled, reading the shared NMI pin.
// - A pin other than the NMI pin carrying a peripheral output is driven regardless of its direction bit.
// - An enabled D/A channel disables the pull-up on its pin.
// - In external-bus modes, direction bits of bus-control pins ignore writes.
// - In external-bus modes, data bits of bus-control pins ignore writes.
// - In external-bus modes, low-port pull-up bits stay writable but pull nothing.
// - With latch-read select set, port one reads its latch regardless of direction.
// - After reset every pin is an input until software sets it to output.

package pio_pkg;

	// ==========================================================
	// Geometry
	localparam int NUM_PORTS     = 11;
	localparam int PORT_WIDTH    = 8;
	localparam int NUM_PINS      = 88;
	localparam int PULL_GROUP    = 4;
	localparam int NUM_PULL_REGS = 3;
	localparam int PULL_BITS     = NUM_PULL_REGS * PORT_WIDTH;
	localparam int SYNC_STAGES   = 2;

	// ==========================================================
	// Special pins and ports
	localparam int NMI_PIN        = 69;
	localparam int LATCH_READ_PORT = 1;
	localparam int DAC0_PIN_DEF   = 75;
	localparam int DAC1_PIN_DEF   = 76;

	// Pins that own no pull-up resistor at all.
	localparam logic [87:0] NO_PULL_MASK    = 88'h0000200300000000000000;
	// Pins whose pull-up is cut in external-bus modes: ports 0-3, port 4 low nibble, port 5.
	localparam logic [87:0] EXT_NOPULL_MASK = 88'h0000000000FF0FFFFFFFFF;
	// Default set of pins that act as bus control lines in external-bus modes.
	localparam logic [87:0] BUS_CTRL_DEF    = 88'h0000000000FFFFFFFFFFFF;

	// ==========================================================
	// Values after reset
	localparam logic [87:0] DIR_RESET   = 88'h0000000000000000000000;
	localparam logic [87:0] LATCH_RESET = 88'h0000000000000000000000;
	localparam logic [23:0] PULL_RESET  = 24'h000000;
	localparam logic        PCR_RESET   = 1'h0;
	localparam int          PCR_LATCH_BIT = 0;

	// ==========================================================
	// Register selection on the write and read ports
	typedef enum logic [1:0] {
		PIO_SEL_DATA = 2'h0,
		PIO_SEL_DIR  = 2'h1,
		PIO_SEL_PULL = 2'h2,
		PIO_SEL_PCR  = 2'h3
	} pio_sel_e;

endpackage

// ### pio_sync_if.sv
// Carrier between the port block and its pin synchroniser.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps

interface pio_sync_if #(
	parameter int WIDTH = 88
);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] level;

	modport src  (output raw, input level);
	modport sink (input raw, output level);
endinterface

// ### pio_pin_sync.sv
// Two-stage synchroniser for the asynchronous pin levels.
// Assumes raw levels may change at any time relative to clk.
`timescale 1ns/1ps

module pio_pin_sync
	import pio_pkg::*;
#(
	parameter int WIDTH = NUM_PINS
)(
	input  wire logic       clk,
	input  wire logic       reset_n,
	pio_sync_if.sink        sync
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} pio_sync_s;

	pio_sync_s st_reg;
	pio_sync_s st_next;

	// ==========================================================
	// Stage one feeds only stage two, so a metastable sample never reaches logic.
	always_comb begin
		st_next        = st_reg;
		st_next.stage1 = sync.raw;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync.level = st_reg.stage2;

endmodule

// ### pio_ports.sv
// Programmable general-purpose port block: direction, data latches,
// pull-up control, peripheral override and external-bus write locking.
// Assumes write and read requests, mode and peripheral signals come from
// logic on clk; only pin_in is asynchronous.
`timescale 1ns/1ps

module pio_ports
	import pio_pkg::*;
#(
	parameter logic [87:0] BUS_CTRL_MASK = BUS_CTRL_DEF,
	parameter int          DAC0_PIN      = DAC0_PIN_DEF,
	parameter int          DAC1_PIN      = DAC1_PIN_DEF
)(
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic [NUM_PINS-1:0] pin_in,
	output logic      [NUM_PINS-1:0] pin_out,
	output logic      [NUM_PINS-1:0] pin_oe,
	output logic      [NUM_PINS-1:0] pin_pullup,
	input  wire logic                ext_bus_mode,
	input  wire logic [NUM_PINS-1:0] periph_out_en,
	input  wire logic [NUM_PINS-1:0] periph_out_val,
	input  wire logic [1:0]          dac_output_enable,
	input  wire logic                wr_en,
	input  wire pio_sel_e            wr_sel,
	input  wire logic [3:0]          wr_index,
	input  wire logic [7:0]          wr_data,
	input  wire pio_sel_e            rd_sel,
	input  wire logic [3:0]          rd_index,
	output logic      [7:0]          rd_data
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [NUM_PINS-1:0]  port_direction_reg;
		logic [NUM_PINS-1:0]  port_data_reg;
		logic [PULL_BITS-1:0] pullup_ctrl;
		logic                 latch_read_select;
		logic [NUM_PINS-1:0]  pin_out;
		logic [NUM_PINS-1:0]  pin_oe;
		logic [NUM_PINS-1:0]  pin_pullup;
		logic [7:0]           rd_data;
	} pio_state_s;

	localparam pio_state_s STATE_RESET = '{
		port_direction_reg: DIR_RESET,
		port_data_reg:      LATCH_RESET,
		pullup_ctrl:        PULL_RESET,
		latch_read_select:  PCR_RESET,
		pin_out:            LATCH_RESET,
		pin_oe:             DIR_RESET,
		pin_pullup:         '0,
		rd_data:            8'h00
	};

	pio_state_s st_reg;
	pio_state_s st_next;

	// ==========================================================
	// Pin level synchroniser
	pio_sync_if #(.WIDTH(NUM_PINS)) sync_bus ();

	assign sync_bus.raw = pin_in;

	pio_pin_sync #(
		.WIDTH (NUM_PINS)
	) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.sync    (sync_bus)
	);

	// ==========================================================
	// Per-pin drive, pull-up and read view
	logic [NUM_PINS-1:0] oe_calc;
	logic [NUM_PINS-1:0] out_calc;
	logic [NUM_PINS-1:0] pull_calc;
	logic [NUM_PINS-1:0] read_view;
	logic [NUM_PINS-1:0] dac_block;
	logic [NUM_PINS-1:0] bus_locked;

	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		localparam bit IS_NMI = (p == NMI_PIN);
		localparam bit IS_DA0 = (p == DAC0_PIN);
		localparam bit IS_DA1 = (p == DAC1_PIN);

		assign dac_block[p] = (IS_DA0 && dac_output_enable[0])
			|| (IS_DA1 && dac_output_enable[1]);

		// The shared NMI pin is never driven, whatever the direction bit holds.
		assign oe_calc[p] = !IS_NMI
			&& (st_reg.port_direction_reg[p] || periph_out_en[p]);

		assign out_calc[p] = periph_out_en[p] ? periph_out_val[p]
			: st_reg.port_data_reg[p];

		// A pull-up only makes sense on an undriven pin, so it follows the drive decision.
		assign pull_calc[p] = st_reg.pullup_ctrl[p / PULL_GROUP]
			&& !oe_calc[p]
			&& !NO_PULL_MASK[p]
			&& !(ext_bus_mode && EXT_NOPULL_MASK[p])
			&& !dac_block[p];

		assign read_view[p] = (st_reg.port_direction_reg[p] && !IS_NMI)
			? st_reg.port_data_reg[p]
			: sync_bus.level[p];

		assign bus_locked[p] = ext_bus_mode && BUS_CTRL_MASK[p];
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic [6:0] wr_base;
		logic [6:0] rd_base;
		logic [6:0] bit_idx;
		logic [4:0] pull_base;
		logic [7:0] rd_word;

		wr_base   = {wr_index, 3'h0};
		rd_base   = {rd_index, 3'h0};
		bit_idx   = 7'h00;
		pull_base = {wr_index[1:0], 3'h0};
		rd_word   = 8'h00;
		st_next   = st_reg;

		// Software writes. Out-of-range indices are dropped without effect.
		if (wr_en) begin
			unique case (wr_sel)
				PIO_SEL_DATA: begin
					if (wr_index < 4'(NUM_PORTS)) begin
						for (int b = 0; b < PORT_WIDTH; b++) begin
							bit_idx = wr_base + 7'(b);
							// Input pins still take the write: only the latch is loaded.
							if (!bus_locked[bit_idx]) begin
								st_next.port_data_reg[bit_idx] = wr_data[b];
							end
						end
					end
				end
				PIO_SEL_DIR: begin
					if (wr_index < 4'(NUM_PORTS)) begin
						for (int b = 0; b < PORT_WIDTH; b++) begin
							bit_idx = wr_base + 7'(b);
							if (!bus_locked[bit_idx]) begin
								st_next.port_direction_reg[bit_idx] = wr_data[b];
							end
						end
					end
				end
				PIO_SEL_PULL: begin
					// Pull-up bits stay writable in every mode; the mode only gates the pads.
					if (wr_index < 4'(NUM_PULL_REGS)) begin
						for (int b = 0; b < PORT_WIDTH; b++) begin
							st_next.pullup_ctrl[pull_base + 5'(b)] = wr_data[b];
						end
					end
				end
				PIO_SEL_PCR: begin
					if (wr_index == 4'h0) begin
						st_next.latch_read_select = wr_data[PCR_LATCH_BIT];
					end
				end
			endcase
		end

		// Read path: the selected word is captured every cycle.
		unique case (rd_sel)
			PIO_SEL_DATA: begin
				if (rd_index < 4'(NUM_PORTS)) begin
					if (st_reg.latch_read_select && rd_index == 4'(LATCH_READ_PORT)) begin
						rd_word = st_reg.port_data_reg[rd_base +: 8];
					end else begin
						rd_word = read_view[rd_base +: 8];
					end
				end
			end
			PIO_SEL_DIR: begin
				if (rd_index < 4'(NUM_PORTS)) begin
					rd_word = st_reg.port_direction_reg[rd_base +: 8];
				end
			end
			PIO_SEL_PULL: begin
				if (rd_index < 4'(NUM_PULL_REGS)) begin
					rd_word = st_reg.pullup_ctrl[{rd_index[1:0], 3'h0} +: 8];
				end
			end
			PIO_SEL_PCR: begin
				if (rd_index == 4'h0) begin
					rd_word = {7'h00, st_reg.latch_read_select};
				end
			end
		endcase
		st_next.rd_data = rd_word;

		// Pad controls are registered so every output leaves a flip-flop.
		st_next.pin_out    = out_calc;
		st_next.pin_oe     = oe_calc;
		st_next.pin_pullup = pull_calc;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_reg <= STATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	assign pin_out    = st_reg.pin_out;
	assign pin_oe     = st_reg.pin_oe;
	assign pin_pullup = st_reg.pin_pullup;
	assign rd_data    = st_reg.rd_data;

endmodule

// ### pio_ports_props.sv
// Assertions on the pins, write port and read port of the port block.
// Assumes the default parameters: bus lock mask and D/A pins of the package.
`timescale 1ns/1ps

module pio_ports_chk
	import pio_pkg::*;
(
	input wire logic                clk,
	input wire logic                reset_n,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] pin_pullup,
	input wire logic                ext_bus_mode,
	input wire logic [NUM_PINS-1:0] periph_out_en,
	input wire logic [NUM_PINS-1:0] periph_out_val,
	input wire logic [1:0]          dac_output_enable,
	input wire logic                wr_en,
	input wire pio_sel_e            wr_sel,
	input wire logic [3:0]          wr_index,
	input wire logic [7:0]          wr_data,
	input wire pio_sel_e            rd_sel,
	input wire logic [3:0]          rd_index,
	input wire logic [7:0]          rd_data
);
	logic [7:0] p2_periph;
	assign p2_periph = periph_out_en[23:16];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Properties
	// The reset check cannot be disabled by the reset it watches.
	reset_clear_a: assert property (disable iff (1'b0) !reset_n |=>
		pin_oe == '0 && pin_out == '0 && pin_pullup == '0) else $error("pins not cleared by reset");
	nmi_input_a: assert property (!pin_oe[NMI_PIN] && !pin_pullup[NMI_PIN])
		else $error("shared interrupt pin driven or pulled");
	pull_input_a: assert property ((pin_pullup & pin_oe) == '0)
		else $error("pull-up on a driven pin");
	periph_oe_a: assert property (|periph_out_en |=> (pin_oe & $past(periph_out_en)) ==
		($past(periph_out_en) & ~(88'h1 << NMI_PIN))) else $error("peripheral pin not driven");
	periph_val_a: assert property (|periph_out_en |=> (pin_out & $past(periph_out_en)) ==
		($past(periph_out_val) & $past(periph_out_en))) else $error("peripheral value lost");
	dac_pull_a: assert property (dac_output_enable[0] |=> !pin_pullup[DAC0_PIN_DEF])
		else $error("pull-up left on D/A pin");
	ext_pull_a: assert property (ext_bus_mode |=> (pin_pullup & EXT_NOPULL_MASK) == '0)
		else $error("pull-up on bus pin in external mode");
	dir_write_a: assert property (wr_en && wr_sel == PIO_SEL_DIR && wr_index == 4'h2 &&
		!ext_bus_mode |-> ##2 pin_oe[23:16] == ($past(wr_data, 2) | $past(p2_periph)))
		else $error("direction write not on pins");
	rd_range_a: assert property (rd_sel == PIO_SEL_DATA && rd_index > 4'hA |=> rd_data == 8'h00)
		else $error("read beyond last port not zero");
endmodule

bind pio_ports pio_ports_chk i_pio_ports_chk (.clk, .reset_n, .pin_out, .pin_oe, .pin_pullup,
	.ext_bus_mode, .periph_out_en, .periph_out_val, .dac_output_enable, .wr_en, .wr_sel,
	.wr_index, .wr_data, .rd_sel, .rd_index, .rd_data);

// ### pio_ext_dev.sv
// External devices on the general-purpose pins.
// Assumes the bench commands which pins it drives and with what value.
`timescale 1ns/1ps

module pio_ext_dev
	import pio_pkg::*;
(
	input  wire logic                clk,
	input  wire logic [NUM_PINS-1:0] pin_out,
	input  wire logic [NUM_PINS-1:0] pin_oe,
	input  wire logic [NUM_PINS-1:0] pin_pullup,
	input  wire logic [NUM_PINS-1:0] ext_en,
	input  wire logic [NUM_PINS-1:0] ext_val,
	output logic      [NUM_PINS-1:0] pin_in
);
	logic [NUM_PINS-1:0] float_reg = '0;
	// A floating, unpulled pin toggles so that no read of it passes by luck.
	always @(posedge clk) float_reg <= ~float_reg;
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			if (pin_oe[p])
				pin_in[p] = pin_out[p];
			else if (ext_en[p])
				pin_in[p] = ext_val[p];
			else
				pin_in[p] = pin_pullup[p] ? 1'b1 : float_reg[p];
		end
	end
endmodule

// ### testbench.sv
// Self-checking bench for the port block with external devices on its pins.
// Assumes the block answers reads one edge late and syncs pins over two edges.
`timescale 1ns/1ps

module testbench;
	import pio_pkg::*;
	logic clk, reset_n, ext_bus_mode, wr_en;
	logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, pin_pullup, periph_out_en, periph_out_val;
	logic [NUM_PINS-1:0] ext_en, ext_val;
	logic [1:0] dac_output_enable;
	pio_sel_e wr_sel, rd_sel;
	logic [3:0] wr_index, rd_index;
	logic [7:0] wr_data, rd_data;
	int fail_count, cmp_count;

	pio_ports i_pio_ports (.clk, .reset_n, .pin_in, .pin_out, .pin_oe, .pin_pullup,
		.ext_bus_mode, .periph_out_en, .periph_out_val, .dac_output_enable, .wr_en,
		.wr_sel, .wr_index, .wr_data, .rd_sel, .rd_index, .rd_data);
	pio_ext_dev i_pio_ext_dev (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);

	// ==========================================================
	// Helpers
	task automatic check(input logic [87:0] seen, input logic [87:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input pio_sel_e s, input logic [3:0] i, input logic [7:0] d);
		wr_en = 1'b1;
		wr_sel = s;
		wr_index = i;
		wr_data = d;
		step(1);
		wr_en = 1'b0;
		step(1);
	endtask
	task automatic rd(input pio_sel_e s, input logic [3:0] i, input logic [7:0] exp);
		rd_sel = s;
		rd_index = i;
		step(1);
		check(rd_data, exp);
	endtask
	task automatic print_verdict;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_port;
		wr(PIO_SEL_DIR, 4'h2, 8'hF0);
		wr(PIO_SEL_DATA, 4'h2, 8'hA5);
		ext_val[23:16] = 8'h3C;
		step(4);
		check(pin_oe[23:16], 8'hF0);
		check(pin_out[23:16], 8'hA5);
		rd(PIO_SEL_DATA, 4'h2, 8'hAC);
		rd(PIO_SEL_DATA, 4'hB, 8'h00);
	endtask
	task automatic t_pull_ext;
		ext_en[23:16] = 8'h00;
		wr(PIO_SEL_PULL, 4'h0, 8'h30);
		step(4);
		check(pin_pullup[23:16], 8'h0F);
		rd(PIO_SEL_DATA, 4'h2, 8'hAF);
		ext_bus_mode = 1'b1;
		wr(PIO_SEL_DIR, 4'h2, 8'h00);
		wr(PIO_SEL_DATA, 4'h2, 8'h00);
		wr(PIO_SEL_PULL, 4'h0, 8'h10);
		check(pin_pullup[23:16], 8'h00);
		check(pin_oe[23:16], 8'hF0);
		check(pin_out[23:16], 8'hA5);
		ext_bus_mode = 1'b0;
		step(2);
		check(pin_pullup[23:16], 8'h0F);
		rd(PIO_SEL_PULL, 4'h0, 8'h10);
		ext_en[23:16] = 8'hFF;
	endtask
	task automatic t_nmi;
		wr(PIO_SEL_PULL, 4'h2, 8'h02);
		wr(PIO_SEL_DIR, 4'h8, 8'hFF);
		ext_val[71:64] = 8'h20;
		step(4);
		check(pin_oe[71:64], 8'hDF);
		check(pin_pullup[71:64], 8'h00);
		rd(PIO_SEL_DATA, 4'h8, 8'h20);
	endtask
	task automatic t_periph_dac;
		wr(PIO_SEL_DIR, 4'h5, 8'h00);
		periph_out_en[47:40] = 8'hFF;
		periph_out_val[47:40] = 8'h5A;
		ext_en[79:72] = 8'h00;
		dac_output_enable = 2'h3;
		wr(PIO_SEL_PULL, 4'h2, 8'h0E);
		step(1);
		check(pin_oe[47:40], 8'hFF);
		check(pin_out[47:40], 8'h5A);
		check(pin_pullup[79:72], 8'hE7);
		dac_output_enable = 2'h1;
		step(2);
		check(pin_pullup[79:72], 8'hF7);
		periph_out_en = '0;
		dac_output_enable = 2'h0;
		ext_en[79:72] = 8'hFF;
	endtask
	task automatic t_latch_read;
		wr(PIO_SEL_DATA, 4'h1, 8'h33);
		ext_val[15:8] = 8'hCC;
		// Two synchroniser stages keep the old level visible for two reads.
		rd(PIO_SEL_DATA, 4'h1, 8'h00);
		rd(PIO_SEL_DATA, 4'h1, 8'h00);
		rd(PIO_SEL_DATA, 4'h1, 8'hCC);
		wr(PIO_SEL_PCR, 4'h0, 8'h01);
		rd(PIO_SEL_PCR, 4'h0, 8'h01);
		rd(PIO_SEL_DATA, 4'h1, 8'h33);
	endtask
	task automatic t_reset;
		reset_n = 1'b0;
		step(3);
		reset_n = 1'b1;
		check(pin_oe, '0);
		check(pin_pullup, '0);
		rd(PIO_SEL_DIR, 4'h2, 8'h00);
	endtask

	// ==========================================================
	// Run
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		print_verdict();
	end
	initial begin
		{reset_n, ext_bus_mode, wr_en, dac_output_enable} = '0;
		{periph_out_en, periph_out_val, ext_val} = '0;
		ext_en = '1;
		wr_sel = PIO_SEL_DATA;
		rd_sel = PIO_SEL_DATA;
		{wr_index, rd_index, wr_data} = '0;
		fail_count = 0;
		cmp_count = 0;
		step(6);
		reset_n = 1'b1;
		// The first write waits until the edge after reset is seen released.
		step(1);
		t_port();
		t_pull_ext();
		t_nmi();
		t_periph_dac();
		t_latch_read();
		t_reset();
		print_verdict();
	end
endmodule
